/* src/amode_pkg.sv */
package amode_pkg;

    // Seventeen operand addressing modes in seven groups.
    typedef enum logic [4:0] {
        AM_INHERENT,
        AM_IMMEDIATE,
        AM_DIR_SHORT,
        AM_DIR_LONG,
        AM_IDX_NOOFS,
        AM_IDX_SHORT,
        AM_IDX_LONG,
        AM_IND_SHORT,
        AM_IND_LONG,
        AM_INDIDX_SHORT,
        AM_INDIDX_LONG,
        AM_REL_DIRECT,
        AM_REL_INDIRECT,
        AM_BIT_DIRECT,
        AM_BIT_INDIRECT,
        AM_BIT_DIR_REL,
        AM_BIT_IND_REL
    } amode_e;

    typedef enum logic [2:0] {
        GRP_INHERENT,
        GRP_IMMEDIATE,
        GRP_DIRECT,
        GRP_INDEXED,
        GRP_INDIRECT,
        GRP_RELATIVE,
        GRP_BIT
    } agroup_e;

    localparam int unsigned MODE_COUNT = 17;
    localparam logic [15:0] PAGE0_LAST = 16'h00FF;
    localparam logic [15:0] IDX_SHORT_LAST = 16'h01FE;
    localparam logic [2:0] LEN_MAX = 3'h4;

    // One decode request: mode, operand bytes and register context.
    typedef struct packed {
        amode_e      mode;
        logic        use_y;
        logic        rmw;
        logic [7:0]  byte1;
        logic [7:0]  byte2;
        logic [7:0]  index;
        logic [15:0] ptr;
        logic [15:0] pc_next;
    } dec_req_s;

    // Decode answer: length, cycles hint, effective address and flags.
    typedef struct packed {
        agroup_e     group;
        logic        short_form;
        logic [2:0]  length;
        logic [2:0]  extra_cycles;
        logic [15:0] eff_addr;
        logic        needs_ptr;
        logic        illegal;
    } dec_rsp_s;

endpackage : amode_pkg

/* src/amode_len.sv */
module amode_len
    import amode_pkg::*;
(
    // Mode in
    input  wire amode_e     mode,
    input  wire logic       use_y,
    // Sizes out
    output logic [2:0]      length,
    output logic [2:0]      extra_cycles,
    output logic            short_form
);

    always_comb begin
        length       = 3'h1;
        extra_cycles = 3'h0;
        short_form   = 1'b1;
        unique case (mode)
            AM_INHERENT: begin
                length = 3'h1;
            end
            AM_IMMEDIATE: begin
                length = 3'h2;
            end
            AM_DIR_SHORT: begin
                length       = 3'h2;
                extra_cycles = 3'h1;
            end
            AM_DIR_LONG: begin
                length       = 3'h3;
                extra_cycles = 3'h2;
                short_form   = 1'b0;
            end
            AM_IDX_NOOFS: begin
                // The Y form needs the index prebyte.
                length       = use_y ? 3'h2 : 3'h1;
                extra_cycles = 3'h1;
            end
            AM_IDX_SHORT: begin
                length       = 3'h2;
                extra_cycles = 3'h1;
            end
            AM_IDX_LONG: begin
                length       = 3'h3;
                extra_cycles = 3'h2;
                short_form   = 1'b0;
            end
            AM_IND_SHORT, AM_INDIDX_SHORT: begin
                length       = 3'h3;
                extra_cycles = 3'h2;
            end
            AM_IND_LONG, AM_INDIDX_LONG: begin
                length       = 3'h3;
                extra_cycles = 3'h3;
                short_form   = 1'b0;
            end
            AM_REL_DIRECT: begin
                length       = 3'h2;
                extra_cycles = 3'h1;
            end
            AM_REL_INDIRECT, AM_BIT_INDIRECT, AM_BIT_DIR_REL: begin
                length       = 3'h3;
                extra_cycles = 3'h2;
            end
            AM_BIT_DIRECT: begin
                length       = 3'h2;
                extra_cycles = 3'h1;
            end
            AM_BIT_IND_REL: begin
                length       = LEN_MAX;
                extra_cycles = 3'h3;
            end
            default: begin
                length = 3'h1;
            end
        endcase
    end

endmodule : amode_len

/* src/amode_decoder.sv */
module amode_decoder
    import amode_pkg::*;
(
    // Clock and reset
    input  wire logic     sys_clk,
    input  wire logic     rst_n,
    // Decode request
    input  wire logic     req_valid,
    input  wire dec_req_s req,
    // Decode answer
    output logic          rsp_valid_ff,
    output dec_rsp_s      rsp_ff
);

    logic [2:0]  length;
    logic [2:0]  extra_cycles;
    logic        short_form;
    agroup_e     nxt_group;
    logic [15:0] nxt_eff_addr;
    logic        nxt_needs_ptr;
    logic        nxt_illegal;
    logic [15:0] rel_target;
    logic [15:0] byte1_ext;
    logic [15:0] index_ext;
    logic [15:0] word_addr;
    logic [15:0] ptr_ext;
    logic [15:0] idx_short_addr;
    logic [15:0] idx_long_addr;
    logic [15:0] indidx_short_addr;
    logic [15:0] indidx_long_addr;
    logic [15:0] rel_ind_target;
    dec_rsp_s    nxt_rsp;

    amode_len u_len (
        .mode         (req.mode),
        .use_y        (req.use_y),
        .length       (length),
        .extra_cycles (extra_cycles),
        .short_form   (short_form)
    );

    assign byte1_ext = {8'h00, req.byte1};
    assign index_ext = {8'h00, req.index};
    assign word_addr = {req.byte1, req.byte2};
    // The PC already points past the jump, so no length correction here.
    assign rel_target = req.pc_next
        + {{8{req.byte1[7]}}, req.byte1};
    assign ptr_ext = {8'h00, req.ptr[7:0]};
    // The sums are formed side by side, so the mode select only muxes.
    assign idx_short_addr = byte1_ext + index_ext;
    assign idx_long_addr = word_addr + index_ext;
    assign indidx_short_addr = ptr_ext + index_ext;
    assign indidx_long_addr = req.ptr + index_ext;
    // Indirect relative: the offset byte was fetched through the pointer.
    assign rel_ind_target = req.pc_next
        + {{8{req.ptr[7]}}, req.ptr[7:0]};

    // Group, address and pointer use are decoded apart, so a change to one
    // table cannot disturb the others.
    always_comb begin
        nxt_group = GRP_INHERENT;
        unique case (req.mode)
            AM_INHERENT: begin
                nxt_group = GRP_INHERENT;
            end
            AM_IMMEDIATE: begin
                nxt_group = GRP_IMMEDIATE;
            end
            AM_DIR_SHORT: begin
                nxt_group = GRP_DIRECT;
            end
            AM_DIR_LONG: begin
                nxt_group = GRP_DIRECT;
            end
            AM_IDX_NOOFS: begin
                nxt_group = GRP_INDEXED;
            end
            AM_IDX_SHORT: begin
                nxt_group = GRP_INDEXED;
            end
            AM_IDX_LONG: begin
                nxt_group = GRP_INDEXED;
            end
            AM_IND_SHORT: begin
                nxt_group = GRP_INDIRECT;
            end
            AM_IND_LONG: begin
                nxt_group = GRP_INDIRECT;
            end
            AM_INDIDX_SHORT: begin
                nxt_group = GRP_INDIRECT;
            end
            AM_INDIDX_LONG: begin
                nxt_group = GRP_INDIRECT;
            end
            AM_REL_DIRECT: begin
                nxt_group = GRP_RELATIVE;
            end
            AM_REL_INDIRECT: begin
                nxt_group = GRP_RELATIVE;
            end
            AM_BIT_DIRECT: begin
                nxt_group = GRP_BIT;
            end
            AM_BIT_INDIRECT: begin
                nxt_group = GRP_BIT;
            end
            AM_BIT_DIR_REL: begin
                nxt_group = GRP_BIT;
            end
            AM_BIT_IND_REL: begin
                nxt_group = GRP_BIT;
            end
            default: begin
                // Codes beyond the seventeen modes decode as inherent.
                nxt_group = GRP_INHERENT;
            end
        endcase
    end

    always_comb begin
        nxt_eff_addr = 16'h0000;
        unique case (req.mode)
            AM_INHERENT, AM_IMMEDIATE: begin
                // No memory operand, so the address is left at zero.
                nxt_eff_addr = 16'h0000;
            end
            AM_DIR_SHORT: begin
                nxt_eff_addr = byte1_ext;
            end
            AM_DIR_LONG: begin
                nxt_eff_addr = word_addr;
            end
            AM_IDX_NOOFS: begin
                nxt_eff_addr = index_ext;
            end
            AM_IDX_SHORT: begin
                nxt_eff_addr = idx_short_addr;
            end
            AM_IDX_LONG: begin
                nxt_eff_addr = idx_long_addr;
            end
            AM_IND_SHORT: begin
                nxt_eff_addr = ptr_ext;
            end
            AM_IND_LONG: begin
                nxt_eff_addr = req.ptr;
            end
            AM_INDIDX_SHORT: begin
                nxt_eff_addr = indidx_short_addr;
            end
            AM_INDIDX_LONG: begin
                nxt_eff_addr = indidx_long_addr;
            end
            AM_REL_DIRECT: begin
                nxt_eff_addr = rel_target;
            end
            AM_REL_INDIRECT: begin
                nxt_eff_addr = rel_ind_target;
            end
            AM_BIT_DIRECT, AM_BIT_DIR_REL: begin
                nxt_eff_addr = byte1_ext;
            end
            AM_BIT_INDIRECT, AM_BIT_IND_REL: begin
                nxt_eff_addr = ptr_ext;
            end
            default: begin
                nxt_eff_addr = 16'h0000;
            end
        endcase
    end

    always_comb begin
        nxt_needs_ptr = 1'b0;
        unique case (req.mode)
            AM_IND_SHORT, AM_IND_LONG,
            AM_INDIDX_SHORT, AM_INDIDX_LONG: begin
                nxt_needs_ptr = 1'b1;
            end
            AM_REL_INDIRECT, AM_BIT_INDIRECT, AM_BIT_IND_REL: begin
                nxt_needs_ptr = 1'b1;
            end
            default: begin
                nxt_needs_ptr = 1'b0;
            end
        endcase
    end

    // Read-modify-write ops may not use long forms; flag it, not fix it.
    assign nxt_illegal = req.rmw && !short_form;

    always_comb begin
        nxt_rsp              = '0;
        nxt_rsp.group        = nxt_group;
        nxt_rsp.short_form   = short_form;
        nxt_rsp.length       = length;
        nxt_rsp.extra_cycles = extra_cycles;
        nxt_rsp.eff_addr     = nxt_eff_addr;
        nxt_rsp.needs_ptr    = nxt_needs_ptr;
        nxt_rsp.illegal      = nxt_illegal;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rsp_valid_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= req_valid;
        end
    end

    // The answer holds between requests, so idle cycles keep the last one.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rsp_ff <= '0;
        end else if (req_valid) begin
            rsp_ff <= nxt_rsp;
        end
    end

endmodule : amode_decoder

/* verification/amode_decoder_monitor.sv */
module amode_decoder_monitor
    import amode_pkg::*;
(
    // Clock and reset
    input wire logic     sys_clk,
    input wire logic     rst_n,
    // Request and answer
    input wire logic     req_valid,
    input wire dec_req_s req,
    input wire logic     rsp_valid_ff,
    input wire dec_rsp_s rsp_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // The request is copied so that answers can be tied to their cause.
    dec_req_s q_ff;

    always_ff @(posedge sys_clk) begin
        q_ff <= req;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_take(amode_e m);
        req_valid && req.mode == m;
    endsequence

    property p_answer;
        req_valid |=> rsp_valid_ff;
    endproperty
    a_answer: assert property (p_answer)
        else $error("answer missing");
    property p_pulse;
        !req_valid |=> !rsp_valid_ff;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("answer without request");
    property p_inh;
        s_take(AM_INHERENT) |=> rsp_ff.length == 3'h1;
    endproperty
    a_inh: assert property (p_inh)
        else $error("inherent length wrong");
    property p_imm;
        s_take(AM_IMMEDIATE) |=> rsp_ff.length == 3'h2;
    endproperty
    a_imm: assert property (p_imm)
        else $error("immediate length wrong");
    property p_dirs;
        s_take(AM_DIR_SHORT) |=> rsp_ff.eff_addr == {8'h00, q_ff.byte1};
    endproperty
    a_dirs: assert property (p_dirs)
        else $error("short direct address wrong");
    property p_dirl;
        s_take(AM_DIR_LONG) |=> rsp_ff.length == 3'h3
            && rsp_ff.eff_addr == {q_ff.byte1, q_ff.byte2};
    endproperty
    a_dirl: assert property (p_dirl)
        else $error("long direct wrong");
    property p_idxs;
        s_take(AM_IDX_SHORT) |=>
            rsp_ff.eff_addr == {8'h00, q_ff.byte1} + {8'h00, q_ff.index};
    endproperty
    a_idxs: assert property (p_idxs)
        else $error("short indexed address wrong");
    property p_rel;
        s_take(AM_REL_DIRECT) |=> rsp_ff.eff_addr ==
            q_ff.pc_next + {{8{q_ff.byte1[7]}}, q_ff.byte1};
    endproperty
    a_rel: assert property (p_rel)
        else $error("relative target wrong");
    property p_rmw;
        req_valid |=> rsp_ff.illegal == (q_ff.rmw && (q_ff.mode inside
            {AM_DIR_LONG, AM_IDX_LONG, AM_IND_LONG, AM_INDIDX_LONG}));
    endproperty
    a_rmw: assert property (p_rmw)
        else $error("illegal flag wrong");
    property p_short;
        req_valid |=> rsp_ff.short_form == !(q_ff.mode inside
            {AM_DIR_LONG, AM_IDX_LONG, AM_IND_LONG, AM_INDIDX_LONG});
    endproperty
    a_short: assert property (p_short)
        else $error("short form flag wrong");
endmodule : amode_decoder_monitor

bind amode_decoder amode_decoder_monitor amode_decoder_monitor_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .rsp_valid_ff(rsp_valid_ff), .rsp_ff(rsp_ff));

/* verification/prog_stream_model.sv */
module prog_stream_model (
    // Fetch address of the opcode
    input  wire logic [15:0] pc,
    // Bytes that follow the opcode
    output logic [7:0]       op1,
    output logic [7:0]       op2
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rom [256];

    // Each byte holds its own low address, so fetch order is visible.
    initial begin
        for (int i = 0; i < 256; i++) begin
            rom[i] = 8'(i);
        end
    end
    assign op1 = rom[8'(pc + 16'h0001)];
    assign op2 = rom[8'(pc + 16'h0002)];
endmodule : prog_stream_model

/* verification/addressing_mode_decoder_tb.sv */
module addressing_mode_decoder_tb
    import amode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req_valid = 1'b0;
    dec_req_s    req = '0;
    logic        rsp_valid_ff;
    dec_rsp_s    rsp_ff;
    logic [15:0] pc = 16'h00AB;
    logic [7:0]  op1;
    logic [7:0]  op2;
    int          num_errors = 0;
    int          n_compared = 0;

    always #4 sys_clk = ~sys_clk;

    amode_decoder amode_decoder_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .req_valid(req_valid), .req(req), .rsp_valid_ff(rsp_valid_ff),
        .rsp_ff(rsp_ff));
    prog_stream_model prog_stream_model_i (.pc(pc), .op1(op1), .op2(op2));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic issue(input dec_req_s r);
        @(posedge sys_clk);
        req       <= r;
        req_valid <= 1'b1;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        #1;
        chk({15'h0, rsp_valid_ff}, 16'h0001);
    endtask : issue

    task automatic t_lengths;
        logic [2:0] lens [17] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h1, 3'h2, 3'h3,
            3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4};
        logic [2:0] ec [17];
        agroup_e    gr [17] = '{GRP_INHERENT, GRP_IMMEDIATE, GRP_DIRECT,
            GRP_DIRECT, GRP_INDEXED, GRP_INDEXED, GRP_INDEXED, GRP_INDIRECT,
            GRP_INDIRECT, GRP_INDIRECT, GRP_INDIRECT, GRP_RELATIVE,
            GRP_RELATIVE, GRP_BIT, GRP_BIT, GRP_BIT, GRP_BIT};
        int         longm = 32'h0000_0548;
        int         ptrm = 32'h0001_5780;
        int         sh [4] = '{2, 5, 7, 9};
        dec_req_s   r;
        r = '0;
        for (int i = 0; i < MODE_COUNT; i++) begin
            r.mode = amode_e'(i);
            issue(r);
            chk(16'(rsp_ff.length), 16'(lens[i]));
            chk(16'(rsp_ff.group), 16'(gr[i]));
            chk(16'(rsp_ff.short_form), 16'(!longm[i]));
            chk(16'(rsp_ff.needs_ptr), 16'(ptrm[i]));
            chk(16'(rsp_ff.illegal), 16'h0000);
            ec[i] = rsp_ff.extra_cycles;
        end
        r.mode = AM_IDX_NOOFS;
        r.use_y = 1'b1;
        issue(r);
        chk(16'(rsp_ff.length), 16'h0002);
        foreach (sh[k]) begin
            chk({15'h0, ec[sh[k]] < ec[sh[k] + 1]}, 16'h0001);
        end
        $display("t_lengths done");
    endtask : t_lengths

    task automatic t_addr;
        dec_req_s r;
        r = '0;
        r.mode = AM_DIR_SHORT;
        r.byte1 = op1;
        issue(r);
        chk(rsp_ff.eff_addr, 16'h00AC);
        r.mode = AM_DIR_LONG;
        r.byte2 = op2;
        issue(r);
        chk(rsp_ff.eff_addr, 16'hACAD);
        r.mode = AM_IDX_SHORT;
        r.byte1 = 8'hFF;
        r.index = 8'hFF;
        issue(r);
        chk(rsp_ff.eff_addr, IDX_SHORT_LAST);
        r.mode = AM_REL_DIRECT;
        r.pc_next = 16'h1000;
        r.byte1 = 8'h80;
        issue(r);
        chk(rsp_ff.eff_addr, 16'h0F80);
        r.byte1 = 8'h7F;
        issue(r);
        chk(rsp_ff.eff_addr, 16'h107F);
        r.mode = AM_REL_INDIRECT;
        r.ptr = 16'hABFF;
        issue(r);
        chk(rsp_ff.eff_addr, 16'h0FFF);
        r.mode = AM_INDIDX_SHORT;
        issue(r);
        chk(rsp_ff.eff_addr, IDX_SHORT_LAST);
        $display("t_addr done");
    endtask : t_addr

    task automatic t_rmw;
        amode_e   lm [5] = '{AM_DIR_LONG, AM_IDX_LONG, AM_IND_LONG,
            AM_INDIDX_LONG, AM_DIR_SHORT};
        dec_req_s r;
        r = '0;
        r.rmw = 1'b1;
        foreach (lm[k]) begin
            r.mode = lm[k];
            issue(r);
            chk({15'h0, rsp_ff.illegal}, {15'h0, k < 4});
        end
        $display("t_rmw done");
    endtask : t_rmw

    task automatic t_reset;
        dec_req_s r;
        r = '0;
        r.mode = AM_DIR_LONG;
        r.byte1 = 8'h12;
        issue(r);
        chk(rsp_ff.eff_addr, 16'h1200);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk(16'(rsp_valid_ff), 16'h0000);
        chk(rsp_ff.eff_addr, 16'h0000);
        $display("t_reset done");
    endtask : t_reset

    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk({15'h0, rsp_valid_ff}, 16'h0000);
        chk(rsp_ff.eff_addr, 16'h0000);
        t_lengths();
        t_addr();
        t_rmw();
        t_reset();
        give_verdict();
    end

    // The whole run needs about 72 cycles, so this leaves a wide margin.
    initial begin
        repeat (2000) @(posedge sys_clk);
        num_errors++;
        give_verdict();
    end
endmodule : addressing_mode_decoder_tb
